/* pspc_sideband.sv */
// Behaviour
// - Two-wire lines only pulled low or released
// - Active-low module-present per port
// - Synchronized, filtered PLL-locked status output
// - Refclocks valid only when input valid, locked
// - Six debug clock taps measured by counters
// - Config done rises when self-config finishes
// - User reset falling restarts self-configuration
// - Port good while supply enabled, drops on fault
// - Optical good while enabled, drops on fault
// - Free-running 40 MHz socket clock domain
`default_nettype none
module pspc_sideband
  import pspc_pkg::*;
#(
  parameter int CFG_CYCLES = PSPC_CFG_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic user_logic_reset,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] port_supply_enable,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] optical_supply_enable,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] over_power_fault,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] module_attached,
  input wire logic ref_input_valid,
  input wire logic ref_pll_lock_raw,
  input wire logic [pspc_pkg::PSPC_DBG_TAPS-1:0] debug_clock_taps,
  input wire logic front_config_ready,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] mdc_user_out,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] mdc_user_oe_n,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] mdd_user_out,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] mdd_user_oe_n,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] module_def_clock_in,
  input wire logic [pspc_pkg::PSPC_PORTS-1:0] module_def_data_in,
  output logic [pspc_pkg::PSPC_PORTS-1:0] module_def_clock_out,
  output logic [pspc_pkg::PSPC_PORTS-1:0] module_def_clock_oe_n,
  output logic [pspc_pkg::PSPC_PORTS-1:0] module_def_data_out,
  output logic [pspc_pkg::PSPC_PORTS-1:0] module_def_data_oe_n,
  output logic [pspc_pkg::PSPC_PORTS-1:0] mdc_user_in,
  output logic [pspc_pkg::PSPC_PORTS-1:0] mdd_user_in,
  output logic [pspc_pkg::PSPC_PORTS-1:0] module_present_n,
  output logic ref_pll_locked,
  output logic ref_clocks_valid,
  output logic front_config_done,
  output logic front_config_prepare,
  output logic [pspc_pkg::PSPC_PORTS-1:0] port_supply_good,
  output logic [pspc_pkg::PSPC_PORTS-1:0] optical_supply_good,
  output logic [pspc_pkg::PSPC_DBG_TAPS*pspc_pkg::PSPC_CNT_W-1:0] debug_tap_counts
);
  import pspc_pkg::*;

  // Three-stage capture; a change counts when stages two and three agree
  logic [2:0] pll_sync_reg;
  logic [2:0] refv_sync_reg;
  logic [2:0] ursel_sync_reg;
  logic pll_reg;
  logic refv_reg;
  logic urst_reg;
  logic [PSPC_PORTS-1:0] attach_s1_reg, attach_s2_reg, attach_s3_reg;
  logic [PSPC_PORTS-1:0] present_n_reg;
  pspc_cfg_e cfg_reg, cfg_next;
  logic [PSPC_CNT_W-1:0] cfg_cnt_reg, cfg_cnt_next;
  pspc_power_s pwr_reg, pwr_next;
  logic [PSPC_CNT_W-1:0] port_cnt_reg [PSPC_PORTS];
  logic [PSPC_CNT_W-1:0] opt_cnt_reg [PSPC_PORTS];
  logic [PSPC_DBG_TAPS-1:0] tap_s1_reg, tap_s2_reg, tap_s3_reg;
  logic [PSPC_CNT_W-1:0] tap_cnt_reg [PSPC_DBG_TAPS];
  logic [PSPC_CNT_W-1:0] tap_cnt_out_reg [PSPC_DBG_TAPS];
  logic [PSPC_CNT_W-1:0] gate_cnt_reg;
  logic gate_end;

  function automatic logic [PSPC_CNT_W-1:0] pspc_settle(input logic en, input logic fault,
                                                       input logic [PSPC_CNT_W-1:0] cnt);
    pspc_settle = (!en || fault) ? '0 :
                  (cnt == PSPC_CNT_W'(PSPC_PWR_CYCLES)) ? cnt : cnt + 1'b1;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_sync_reg <= '0;
      refv_sync_reg <= '0;
      // Filter starts at the held-reset level so a low input after reset reads as a fall
      ursel_sync_reg <= '1;
      pll_reg <= PSPC_BIT_RST;
      refv_reg <= PSPC_BIT_RST;
      urst_reg <= 1'b1;
      attach_s1_reg <= PSPC_PORT_RST;
      attach_s2_reg <= PSPC_PORT_RST;
      attach_s3_reg <= PSPC_PORT_RST;
      present_n_reg <= PSPC_PRESENT_RST;
    end else begin
      pll_sync_reg <= {pll_sync_reg[1:0], ref_pll_lock_raw};
      refv_sync_reg <= {refv_sync_reg[1:0], ref_input_valid};
      ursel_sync_reg <= {ursel_sync_reg[1:0], user_logic_reset};
      if (pll_sync_reg[1] == pll_sync_reg[2]) pll_reg <= pll_sync_reg[2];
      if (refv_sync_reg[1] == refv_sync_reg[2]) refv_reg <= refv_sync_reg[2];
      if (ursel_sync_reg[1] == ursel_sync_reg[2]) urst_reg <= ursel_sync_reg[2];
      attach_s1_reg <= module_attached;
      attach_s2_reg <= attach_s1_reg;
      attach_s3_reg <= attach_s2_reg;
      for (int i = 0; i < PSPC_PORTS; i++) begin
        if (attach_s2_reg[i] == attach_s3_reg[i]) present_n_reg[i] <= !attach_s3_reg[i];
      end
    end
  end

  assign ref_pll_locked = pll_reg;
  assign ref_clocks_valid = refv_reg & pll_reg;
  assign module_present_n = present_n_reg;

  // Self-configuration sequencer
  // Level start, not edge: a user reset held low from power-up still configures
  always_comb begin
    cfg_next = cfg_reg;
    cfg_cnt_next = cfg_cnt_reg;
    unique case (cfg_reg)
      PSPC_CFG_IDLE: begin
        if (!urst_reg) begin
          cfg_next = PSPC_CFG_RUN;
          cfg_cnt_next = '0;
        end
      end
      PSPC_CFG_RUN: begin
        if (urst_reg) cfg_next = PSPC_CFG_IDLE;
        else if (cfg_cnt_reg == PSPC_CNT_W'(CFG_CYCLES - 1)) cfg_next = PSPC_CFG_DONE;
        else cfg_cnt_next = cfg_cnt_reg + 1'b1;
      end
      PSPC_CFG_DONE: begin
        if (urst_reg) cfg_next = PSPC_CFG_IDLE;
      end
      default: cfg_next = PSPC_CFG_IDLE;
    endcase
  end

  // Power supplies: good after settle time, dropped on over-power
  // A fault clears the settle count, so recovery always waits the full settle time
  always_comb begin
    pwr_next = pwr_reg;
    for (int i = 0; i < PSPC_PORTS; i++) begin
      pwr_next.port_good[i] = port_supply_enable[i] && !over_power_fault[i] &&
                              port_cnt_reg[i] == PSPC_CNT_W'(PSPC_PWR_CYCLES);
      pwr_next.optical_good[i] = optical_supply_enable[i] && !over_power_fault[i] &&
                                 opt_cnt_reg[i] == PSPC_CNT_W'(PSPC_PWR_CYCLES);
    end
  end

  // Gate length sets the unit of the counts: rising edges per millisecond
  assign gate_end = (gate_cnt_reg == PSPC_CNT_W'(PSPC_GATE_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= PSPC_CFG_IDLE;
      cfg_cnt_reg <= '0;
      pwr_reg <= '0;
      gate_cnt_reg <= '0;
      tap_s1_reg <= '0;
      tap_s2_reg <= '0;
      tap_s3_reg <= '0;
      for (int i = 0; i < PSPC_PORTS; i++) begin
        port_cnt_reg[i] <= '0;
        opt_cnt_reg[i] <= '0;
      end
      for (int i = 0; i < PSPC_DBG_TAPS; i++) begin
        tap_cnt_reg[i] <= '0;
        tap_cnt_out_reg[i] <= '0;
      end
    end else begin
      cfg_reg <= cfg_next;
      cfg_cnt_reg <= cfg_cnt_next;
      pwr_reg <= pwr_next;
      for (int i = 0; i < PSPC_PORTS; i++) begin
        port_cnt_reg[i] <= pspc_settle(port_supply_enable[i], over_power_fault[i], port_cnt_reg[i]);
        opt_cnt_reg[i] <= pspc_settle(optical_supply_enable[i], over_power_fault[i], opt_cnt_reg[i]);
      end
      // Sampled tap counter: only resolves taps below half the socket clock
      gate_cnt_reg <= gate_end ? '0 : gate_cnt_reg + 1'b1;
      tap_s1_reg <= debug_clock_taps;
      tap_s2_reg <= tap_s1_reg;
      tap_s3_reg <= tap_s2_reg;
      for (int i = 0; i < PSPC_DBG_TAPS; i++) begin
        if (gate_end) begin
          tap_cnt_out_reg[i] <= tap_cnt_reg[i];
          tap_cnt_reg[i] <= '0;
        end else if (tap_s2_reg[i] && !tap_s3_reg[i]) begin
          tap_cnt_reg[i] <= tap_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  assign front_config_done = (cfg_reg == PSPC_CFG_DONE);
  // Reserved handshake: prepare stands after configuration until ready answers
  assign front_config_prepare = front_config_done & ~front_config_ready;
  assign port_supply_good = pwr_reg.port_good;
  assign optical_supply_good = pwr_reg.optical_good;

  genvar g;
  generate
    for (g = 0; g < PSPC_DBG_TAPS; g++) begin : g_tap
      assign debug_tap_counts[g*PSPC_CNT_W +: PSPC_CNT_W] = tap_cnt_out_reg[g];
    end
  endgenerate

  // Device side of the link only ever pulls low; disabled while port supply is off
  assign module_def_clock_out = '0;
  assign module_def_data_out = '0;
  assign module_def_clock_oe_n = ~(port_supply_enable & ~mdc_user_oe_n & ~mdc_user_out);
  assign module_def_data_oe_n = ~(port_supply_enable & ~mdd_user_oe_n & ~mdd_user_out);
  // Reads are forced high while unpowered so user logic sees an idle bus
  assign mdc_user_in = module_def_clock_in | ~port_supply_enable;
  assign mdd_user_in = module_def_data_in | ~port_supply_enable;
endmodule
`default_nettype wire

/* pspc_pkg.sv */
`default_nettype none
package pspc_pkg;
  localparam int PSPC_PORTS = 6;
  localparam int PSPC_DBG_TAPS = 6;
  localparam int PSPC_CLK_HZ = 40000000;
  // Self-configuration run time after user reset release
  localparam int PSPC_CFG_TIME_US = 100;
  localparam int PSPC_CFG_CYCLES = (PSPC_CFG_TIME_US * (PSPC_CLK_HZ / 1000000));
  // Supply settle time before power-good rises
  localparam int PSPC_PWR_TIME_US = 10;
  localparam int PSPC_PWR_CYCLES = (PSPC_PWR_TIME_US * (PSPC_CLK_HZ / 1000000));
  localparam int PSPC_CNT_W = 16;
  localparam logic [5:0] PSPC_PORT_RST = 6'h00;
  localparam logic [5:0] PSPC_PRESENT_RST = 6'h3F;
  // Tap counter gate: one millisecond of socket clock
  localparam int PSPC_GATE_CYCLES = PSPC_CLK_HZ / 1000;
  localparam logic PSPC_BIT_RST = 1'b0;

  typedef struct packed {
    logic [PSPC_PORTS-1:0] port_good;
    logic [PSPC_PORTS-1:0] optical_good;
  } pspc_power_s;

  typedef struct packed {
    logic [PSPC_PORTS-1:0] line_out;
    logic [PSPC_PORTS-1:0] line_oe_n;
  } pspc_od_s;

  typedef enum logic [1:0] {
    PSPC_CFG_IDLE = 2'b00,
    PSPC_CFG_RUN = 2'b01,
    PSPC_CFG_DONE = 2'b10
  } pspc_cfg_e;
endpackage
`default_nettype wire

/* pspc_sideband_properties.sv */
`default_nettype none
module pspc_sideband_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic user_logic_reset,
  input wire logic front_config_ready,
  input wire logic front_config_done,
  input wire logic front_config_prepare,
  input wire logic ref_input_valid,
  input wire logic ref_clocks_valid,
  input wire logic [5:0] port_supply_enable,
  input wire logic [5:0] optical_supply_enable,
  input wire logic [5:0] port_supply_good,
  input wire logic [5:0] optical_supply_good,
  input wire logic [5:0] module_def_clock_oe_n,
  input wire logic [5:0] module_def_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_prep_follow: assert property (front_config_prepare == (front_config_done & ~front_config_ready))
    else $error("prepare wrong");
  // Lower bound only; any run shorter than 8 cycles is too early
  a_done_restart: assert property ($fell(user_logic_reset) |-> !front_config_done[*8])
    else $error("done too early");
  a_done_clear: assert property (user_logic_reset[*6] |-> !front_config_done)
    else $error("done during reset");
  a_done_hold: assert property (front_config_done && !user_logic_reset |=> front_config_done)
    else $error("done dropped");
  a_valid_gate: assert property (!ref_input_valid[*5] |-> !ref_clocks_valid)
    else $error("valid without input");
  a_pgood_time: assert property ($rose(port_supply_enable[0]) |-> ##[390:420] port_supply_good[0])
    else $error("port good late");
  a_pgood_off: assert property ((port_supply_good & ~port_supply_enable & ~$past(port_supply_enable)) == 6'h00)
    else $error("port good unpowered");
  a_ogood_off: assert property ((optical_supply_good & ~optical_supply_enable & ~$past(optical_supply_enable)) == 6'h00)
    else $error("optical good unpowered");
  a_od_low: assert property (module_def_clock_out == 6'h00)
    else $error("line driven high");
  a_od_gate: assert property ((~module_def_clock_oe_n & ~port_supply_enable & ~$past(port_supply_enable)) == 6'h00)
    else $error("link used unpowered");
  c_done: cover property ($rose(front_config_done));
  c_pgood: cover property ($rose(port_supply_good[0]));
  c_valid: cover property ($rose(ref_clocks_valid));
endmodule
`default_nettype wire

/* pspc_far_model.sv */
`default_nettype none
module pspc_far_model #(
  parameter int LOCK_DLY = 20
) (
  input wire logic clk,
  input wire logic src_on,
  input wire logic [5:0] clk_oe_n,
  input wire logic [5:0] data_oe_n,
  input wire logic [5:0] mod_low,
  output logic ref_input_valid,
  output logic ref_pll_lock_raw,
  output logic [5:0] clk_pad,
  output logic [5:0] data_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Lock lags the source so a valid without lock is visible
  always_ff @(posedge clk) cnt <= !src_on ? 0 : (cnt < LOCK_DLY ? cnt + 1 : cnt);
  assign ref_input_valid = src_on;
  assign ref_pll_lock_raw = (cnt == LOCK_DLY);
  // Pull-up wins unless someone pulls low; nobody drives high
  assign clk_pad = clk_oe_n;
  assign data_pad = data_oe_n & ~mod_low;
endmodule
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pspc_pkg::*;
  logic clk = 0, resetn = 0, user_logic_reset = 1, front_config_ready = 0, src_on = 0;
  logic [5:0] port_supply_enable = '0, optical_supply_enable = '0, over_power_fault = '0, module_attached = '0;
  logic [5:0] debug_clock_taps = '0, mdc_user_out = '0, mdc_user_oe_n = '1, mdd_user_out = '0, mdd_user_oe_n = '1;
  logic [5:0] mod_low = '0, module_def_clock_in, module_def_data_in, module_def_clock_out, module_def_clock_oe_n;
  logic [5:0] module_def_data_out, module_def_data_oe_n, mdc_user_in, mdd_user_in, module_present_n;
  logic [5:0] port_supply_good, optical_supply_good;
  logic ref_input_valid, ref_pll_lock_raw, ref_pll_locked, ref_clocks_valid, front_config_done, front_config_prepare;
  logic [95:0] debug_tap_counts;
  int err_count = 0, tests_run = 0;
  pspc_far_model #(.LOCK_DLY(20)) pspc_far_model_i (.clk(clk), .src_on(src_on), .clk_oe_n(module_def_clock_oe_n),
    .data_oe_n(module_def_data_oe_n), .mod_low(mod_low), .ref_input_valid(ref_input_valid),
    .ref_pll_lock_raw(ref_pll_lock_raw), .clk_pad(module_def_clock_in), .data_pad(module_def_data_in));
  pspc_sideband #(.CFG_CYCLES(8)) pspc_sideband_i (
    .clk(clk), .resetn(resetn), .user_logic_reset(user_logic_reset), .port_supply_enable(port_supply_enable),
    .optical_supply_enable(optical_supply_enable), .over_power_fault(over_power_fault),
    .module_attached(module_attached), .ref_input_valid(ref_input_valid), .ref_pll_lock_raw(ref_pll_lock_raw),
    .debug_clock_taps(debug_clock_taps), .front_config_ready(front_config_ready), .mdc_user_out(mdc_user_out),
    .mdc_user_oe_n(mdc_user_oe_n), .mdd_user_out(mdd_user_out), .mdd_user_oe_n(mdd_user_oe_n),
    .module_def_clock_in(module_def_clock_in), .module_def_data_in(module_def_data_in),
    .module_def_clock_out(module_def_clock_out), .module_def_clock_oe_n(module_def_clock_oe_n),
    .module_def_data_out(module_def_data_out), .module_def_data_oe_n(module_def_data_oe_n),
    .mdc_user_in(mdc_user_in), .mdd_user_in(mdd_user_in), .module_present_n(module_present_n),
    .ref_pll_locked(ref_pll_locked), .ref_clocks_valid(ref_clocks_valid), .front_config_done(front_config_done),
    .front_config_prepare(front_config_prepare), .port_supply_good(port_supply_good),
    .optical_supply_good(optical_supply_good), .debug_tap_counts(debug_tap_counts));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_config;
    int n;
    cyc(10);
    chk(front_config_done, 1'b0);
    @(posedge clk);
    user_logic_reset <= 0;
    for (n = 0; n < 40 && front_config_done !== 1'b1; n++) cyc(1);
    chk(n >= 8 && n < 40, 1'b1);
    chk(front_config_prepare, 1'b1);
    @(posedge clk);
    front_config_ready <= 1;
    cyc(1);
    chk({front_config_done, front_config_prepare}, 2'b10);
    @(posedge clk);
    user_logic_reset <= 1;
    front_config_ready <= 0;
    cyc(6);
    chk(front_config_done, 1'b0);
    @(posedge clk);
    user_logic_reset <= 0;
    cyc(16);
    chk({front_config_done, front_config_prepare}, 2'b11);
    $display("test config done");
  endtask
  task t_status;
    chk(front_config_done, 1'b1);
    @(posedge clk);
    src_on <= 1;
    module_attached <= 6'h15;
    cyc(8);
    chk(ref_clocks_valid, 1'b0);
    chk(module_present_n, 6'h2A);
    cyc(30);
    chk({ref_pll_locked, ref_clocks_valid}, 2'b11);
    @(posedge clk);
    src_on <= 0;
    cyc(8);
    chk({ref_pll_locked, ref_clocks_valid}, 2'b00);
    $display("test status done");
  endtask
  task t_power;
    @(posedge clk);
    port_supply_enable <= 6'h3F;
    optical_supply_enable <= 6'h21;
    cyc(380);
    chk(port_supply_good, 6'h00);
    cyc(40);
    chk({port_supply_good, optical_supply_good}, 12'hFE1);
    @(posedge clk);
    over_power_fault <= 6'h02;
    cyc(3);
    chk(port_supply_good, 6'h3D);
    @(posedge clk);
    over_power_fault <= 6'h00;
    port_supply_enable <= 6'h00;
    optical_supply_enable <= 6'h00;
    cyc(3);
    chk({port_supply_good, optical_supply_good}, 12'h000);
    $display("test power done");
  endtask
  task t_link;
    @(posedge clk);
    port_supply_enable <= 6'h01;
    mod_low <= 6'h01;
    cyc(PSPC_PWR_CYCLES + 5);
    chk(port_supply_good, 6'h01);
    @(posedge clk);
    mdc_user_oe_n <= 6'h00;
    cyc(3);
    chk(module_def_clock_oe_n, 6'h3E);
    chk(mdc_user_in, 6'h3E);
    chk(mdd_user_in, 6'h3E);
    chk({module_def_data_out, module_def_data_oe_n}, 12'h03F);
    @(posedge clk);
    mdc_user_oe_n <= 6'h3F;
    cyc(3);
    chk(mdc_user_in, 6'h3F);
    $display("test link done");
  endtask
  task t_taps;
    int k;
    for (k = 0; k < 10; k++) begin
      @(posedge clk);
      debug_clock_taps <= 6'h21;
      repeat (2) @(posedge clk);
      debug_clock_taps <= 6'h00;
      @(posedge clk);
    end
    cyc(PSPC_GATE_CYCLES);
    chk(debug_tap_counts[15:0], 16'h000A);
    chk(debug_tap_counts[95:80], 16'h000A);
    chk(|debug_tap_counts[79:16], 1'b0);
    $display("test taps done");
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    t_config;
    t_status;
    t_power;
    t_link;
    t_taps;
    summarize;
  end
  initial begin
    repeat (45000) @(posedge clk);
    err_count++;
    $display("BAD t=%0t watchdog", $time);
    summarize;
  end
endmodule
bind pspc_sideband pspc_sideband_chk pspc_sideband_chk_i (
  .clk(clk), .resetn(resetn), .user_logic_reset(user_logic_reset), .front_config_ready(front_config_ready),
  .front_config_done(front_config_done), .front_config_prepare(front_config_prepare),
  .ref_input_valid(ref_input_valid), .ref_clocks_valid(ref_clocks_valid),
  .port_supply_enable(port_supply_enable), .optical_supply_enable(optical_supply_enable),
  .port_supply_good(port_supply_good), .optical_supply_good(optical_supply_good),
  .module_def_clock_oe_n(module_def_clock_oe_n), .module_def_clock_out(module_def_clock_out));
`default_nettype wire
